// ---- design/dfc_cmd_decoder.sv ----
// How it works
// - format control acts only on standard or enhanced long frames
// - broadcast address executes format control but sends no response
// - command code 1010 decodes as format control
// - otherwise address must equal programmed address or command is ignored
// - data byte holds selector bit 7, index bits 6-4, value bits 3-0
// - selector 1 writes the indexed register, selector 0 only reads
// - response: address, 0110, selector, index, then register data on a read or the written value on a write
// - unused nibble codes store nothing and answer with the device address
// - bank 10 nibble 0110 stores data bit 1 into the mode bit
// - bank 01 nibbles 1101 and 1110 fill low nibble of user bytes six, seven
// - bank 10 nibbles 1000 up fill user high nibbles, bank 11 unused
// - one-time array is programmed only while nonvolatile enable is set
// - selection 1111 activates programmed values, 0000 standard, else ignored
// - crc length above 8 and short length below 8 are ignored
module dfc_cmd_decoder
	import dfc_pkg::*;
(
	input  wire logic                    clk_sys,         // system clock
	input  wire logic                    arst_n,          // async reset
	input  wire logic                    cmdValid,        // one-cycle command strobe
	input  wire dfc_cmd_t                cmd,             // decoded frame fields
	input  wire logic                    frameEnd,        // one-cycle end of frame
	input  wire logic [3:0]              devAddr,         // programmed address
	input  wire logic                    nonvolatileEnableFlag, // program one-time array
	output dfc_resp_t                    resp,            // response word
	output logic                         respValid,       // one-cycle response strobe
	output logic                         fmtActive,       // programmed format in force
	output logic                         modeBit,         // operating mode mirror
	output logic [USER_BYTES*8-1:0]      userBytes,       // user byte mirrors
	output logic                         otpProgram,      // one-cycle program pulse
	output logic [5:0]                   otpWhere         // bank and nibble programmed
);
	import dfc_pkg::*;

	// ****************************************
	// decode
	// ****************************************
	logic       longFrame;
	logic       bcast;
	logic       addrHit;
	logic       isFmt;
	logic       isNvm;
	logic       fmtRw;
	logic [2:0] fmtIdx;
	logic [3:0] fmtVal;
	logic [3:0] bankVal;
	logic       pendWr;
	logic [2:0] pendIdx;
	logic [3:0] pendVal;
	logic [3:0] otpNibbleIndex;
	logic [3:0] wrData;

	assign longFrame = (cmd.frame == DFC_FRM_STD_LONG) || (cmd.frame == DFC_FRM_ENH_LONG);
	assign bcast     = (cmd.addr == ADDR_BROADCAST);
	assign addrHit   = (cmd.addr == devAddr);
	assign isFmt     = cmdValid && longFrame && (cmd.code == CMD_FORMAT_CTRL)
	                   && (bcast || addrHit);
	assign isNvm     = cmdValid && (cmd.code == CMD_WRITE_NVM) && addrHit && !bcast;
	assign fmtRw     = cmd.data[RW_BIT];
	assign fmtIdx    = cmd.data[IDX_HI:IDX_LO];
	assign fmtVal    = cmd.data[VAL_HI:VAL_LO];
	assign otpNibbleIndex = cmd.data[7:4];
	assign wrData    = cmd.data[3:0];

	// ****************************************
	// format bank; write held to frame end
	// ****************************************
	dfc_format_bank u_bank (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.wrEn      (pendWr && frameEnd),
		.wrIdx     (pendIdx),
		.wrVal     (pendVal),
		.rdIdx     (fmtIdx),
		.rdVal     (bankVal),
		.fmtActive (fmtActive)
	);

	// response is built now, so old settings frame it
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pendWr  <= 1'b0;
			pendIdx <= 3'h0;
			pendVal <= 4'h0;
		end else if (isFmt && fmtRw) begin
			pendWr  <= 1'b1;
			pendIdx <= fmtIdx;
			pendVal <= fmtVal;
		end else if (frameEnd) begin
			pendWr  <= 1'b0;
		end
	end

	// ****************************************
	// nibble map
	// ****************************************
	typedef enum logic [1:0] {
		DFC_NIB_UNUSED = 2'b00,
		DFC_NIB_MODE   = 2'b01,
		DFC_NIB_LOW    = 2'b10,
		DFC_NIB_HIGH   = 2'b11
	} dfc_nib_t;

	dfc_nib_t   nibKind;
	logic [2:0] userSel;
	logic [3:0] nextReadback;

	always_comb begin
		nibKind = DFC_NIB_UNUSED;
		userSel = 3'h0;
		if (cmd.bank == BANK_HIGH && otpNibbleIndex == NIB_MODE) begin
			nibKind = DFC_NIB_MODE;
		end else if (cmd.bank == BANK_LOW && otpNibbleIndex == NIB_UD6_LO) begin
			nibKind = DFC_NIB_LOW;
			userSel = 3'h5;
		end else if (cmd.bank == BANK_LOW && otpNibbleIndex == NIB_UD7_LO) begin
			nibKind = DFC_NIB_LOW;
			userSel = 3'h6;
		end else if (cmd.bank == BANK_HIGH && otpNibbleIndex >= NIB_UD_HI) begin
			nibKind = DFC_NIB_HIGH;
			userSel = otpNibbleIndex[2:0];
		end
	end

	// mirror view after the write, for the response
	always_comb begin
		unique case (nibKind)
			DFC_NIB_MODE: nextReadback = {2'b00, wrData[MODE_BIT], 1'b0};
			DFC_NIB_LOW:  nextReadback = wrData;
			DFC_NIB_HIGH: nextReadback = wrData;
			default:      nextReadback = devAddr;
		endcase
	end

	// mirrors follow every write; the array only with the flag
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			modeBit <= 1'b0;
		end else if (isNvm && nibKind == DFC_NIB_MODE) begin
			modeBit <= wrData[MODE_BIT];
		end
	end

	for (genvar b = 0; b < USER_BYTES; b++) begin : g_user
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				userBytes[8*b +: 8] <= 8'h00;
			end else if (isNvm && userSel == 3'(b)) begin
				if (nibKind == DFC_NIB_LOW) begin
					userBytes[8*b +: 4] <= wrData;
				end else if (nibKind == DFC_NIB_HIGH) begin
					userBytes[8*b+4 +: 4] <= wrData;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			otpProgram <= 1'b0;
			otpWhere   <= 6'h00;
		end else begin
			otpProgram <= isNvm && nonvolatileEnableFlag && nibKind != DFC_NIB_UNUSED;
			otpWhere   <= {cmd.bank, otpNibbleIndex};
		end
	end

	// ****************************************
	// response
	// ****************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			respValid <= 1'b0;
			resp      <= '0;
		end else begin
			respValid <= (isFmt && !bcast) || isNvm;
			if (isFmt) begin
				resp <= '{addr: devAddr, tag: RESP_FMT_TAG,
				          body: {fmtRw, fmtIdx, fmtRw ? fmtVal : bankVal}};
			end else if (isNvm) begin
				resp <= '{addr: devAddr,
				          tag: (nonvolatileEnableFlag ? otpNibbleIndex : 4'h0),
				          body: {RESP_NVM_TAG, (nonvolatileEnableFlag ? cmd.bank : 2'b11),
				                 (nonvolatileEnableFlag ? nextReadback : devAddr)}};
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_bcast_silent: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(isFmt && bcast) |=> !respValid) else $error("broadcast answered");
	a_short_dropped: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(cmdValid && !longFrame && cmd.code == CMD_FORMAT_CTRL) |=> !respValid)
		else $error("short frame answered");
	a_wrong_addr: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(cmdValid && !bcast && !addrHit) |=> !respValid && !otpProgram)
		else $error("foreign address served");
	a_fmt_resp_shape: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(isFmt && !bcast) |=> respValid && resp.tag == RESP_FMT_TAG
		&& resp.body[6:4] == $past(fmtIdx)) else $error("bad format response");
	a_read_keeps: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(isFmt && !fmtRw && !pendWr) |=> !pendWr) else $error("read scheduled write");
	a_write_late: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(isFmt && fmtRw && !frameEnd) |=> pendWr) else $error("write not held");
	a_unused_safe: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(isNvm && nibKind == DFC_NIB_UNUSED) |=> !otpProgram
		&& resp.body[3:0] == devAddr && $stable(userBytes)) else $error("unused nibble stored");
	a_flag_gates: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(cmdValid && !nonvolatileEnableFlag) |=> !otpProgram) else $error("otp without flag");
	a_mode_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(isNvm && nibKind == DFC_NIB_MODE) |=> modeBit == $past(wrData[MODE_BIT]))
		else $error("mode bit not stored");
	a_nvm_answer: assert property (@(posedge clk_sys) disable iff (!arst_n)
		isNvm |=> respValid) else $error("nvm request unanswered");
	a_fmt_echo: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(isFmt && !bcast && fmtRw) |=> resp.body[3:0] == $past(fmtVal))
		else $error("written value not echoed");

	c_fmt_write: cover property (@(posedge clk_sys) isFmt && fmtRw && !bcast);
	c_nvm_unused: cover property (@(posedge clk_sys) isNvm && nibKind == DFC_NIB_UNUSED);
	c_fmt_bcast: cover property (@(posedge clk_sys) isFmt && bcast);
	c_nvm_high:  cover property (@(posedge clk_sys) isNvm && nibKind == DFC_NIB_HIGH);
	c_otp_prog:  cover property (@(posedge clk_sys) otpProgram);

endmodule // dfc_cmd_decoder

// ---- design/dfc_pkg.sv ----
package dfc_pkg;

	// ****************************************
	// command codes and frame formats
	// ****************************************
	localparam logic [3:0] CMD_FORMAT_CTRL = 4'ha;
	localparam logic [3:0] CMD_WRITE_NVM   = 4'h9;
	localparam logic [3:0] ADDR_BROADCAST  = 4'h0;
	localparam logic [3:0] RESP_FMT_TAG    = 4'h6;
	localparam logic [1:0] RESP_NVM_TAG    = 2'h3;

	typedef enum logic [1:0] {
		DFC_FRM_STD_LONG = 2'b00,
		DFC_FRM_ENH_LONG = 2'b01,
		DFC_FRM_SHORT    = 2'b10,
		DFC_FRM_OTHER    = 2'b11
	} dfc_frame_t;

	// ****************************************
	// command data byte layout
	// ****************************************
	localparam int RW_BIT    = 7;
	localparam int IDX_HI    = 6;
	localparam int IDX_LO    = 4;
	localparam int VAL_HI    = 3;
	localparam int VAL_LO    = 0;

	typedef struct packed {
		dfc_frame_t frame;
		logic [7:0] data;
		logic [3:0] addr;
		logic [3:0] code;
		logic [1:0] bank;
	} dfc_cmd_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [3:0] tag;
		logic [7:0] body;
	} dfc_resp_t;

	// ****************************************
	// format register indices and reset values
	// ****************************************
	localparam logic [2:0] FREG_CRC_LEN = 3'h4;
	localparam logic [2:0] FREG_SW_LEN  = 3'h5;
	localparam logic [2:0] FREG_RSVD    = 3'h6;
	localparam logic [2:0] FREG_SELECT  = 3'h7;
	localparam logic [3:0] CRC_LEN_MAX  = 4'h8;
	localparam logic [3:0] SW_LEN_MIN   = 4'h8;
	localparam logic [3:0] SEL_ACTIVE   = 4'hf;
	localparam logic [3:0] SEL_STANDARD = 4'h0;
	localparam logic [31:0] FREG_RESET  = 32'h0084_0a11;

	// ****************************************
	// nonvolatile nibble map
	// ****************************************
	localparam logic [1:0] BANK_LOW    = 2'b01;
	localparam logic [1:0] BANK_HIGH   = 2'b10;
	localparam logic [3:0] NIB_MODE    = 4'h6;
	localparam logic [3:0] NIB_UD6_LO  = 4'hd;
	localparam logic [3:0] NIB_UD7_LO  = 4'he;
	localparam logic [3:0] NIB_UD_HI   = 4'h8;
	localparam int         MODE_BIT    = 1;
	localparam int         USER_BYTES  = 8;

endpackage : dfc_pkg

// ---- design/dfc_format_bank.sv ----
module dfc_format_bank
	import dfc_pkg::*;
(
	input  wire logic       clk_sys,   // system clock
	input  wire logic       arst_n,    // async reset
	input  wire logic       wrEn,      // write request, frame-end
	input  wire logic [2:0] wrIdx,     // register index
	input  wire logic [3:0] wrVal,     // value written
	input  wire logic [2:0] rdIdx,     // read index
	output logic      [3:0] rdVal,     // stored value
	output logic            fmtActive  // programmed values in force
);
	import dfc_pkg::*;

	logic [3:0] regs [8];
	logic       accept;

	// ****************************************
	// write filtering
	// ****************************************
	always_comb begin
		unique case (wrIdx)
			FREG_CRC_LEN: accept = (wrVal <= CRC_LEN_MAX);
			FREG_SW_LEN:  accept = (wrVal >= SW_LEN_MIN);
			FREG_SELECT:  accept = (wrVal == SEL_ACTIVE) || (wrVal == SEL_STANDARD);
			default:      accept = 1'b1;
		endcase
	end

	for (genvar i = 0; i < 8; i++) begin : g_reg
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				regs[i] <= FREG_RESET[4*i +: 4];
			end else if (wrEn && accept && wrIdx == 3'(i)) begin
				regs[i] <= wrVal;
			end
		end
	end

	assign rdVal     = regs[rdIdx];

	// registered copy of the selection decode, so the top output comes from a flop
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fmtActive <= 1'b0;
		end else if (wrEn && accept && wrIdx == FREG_SELECT) begin
			fmtActive <= (wrVal == SEL_ACTIVE);
		end
	end

	a_sel_mirror: assert property (@(posedge clk_sys) disable iff (!arst_n)
		fmtActive == (regs[FREG_SELECT] == SEL_ACTIVE)) else $error("selection flag out of step");

	a_crc_len_cap: assert property (@(posedge clk_sys) disable iff (!arst_n)
		regs[FREG_CRC_LEN] <= CRC_LEN_MAX) else $error("crc length above limit");
	a_sw_len_floor: assert property (@(posedge clk_sys) disable iff (!arst_n)
		regs[FREG_SW_LEN] >= SW_LEN_MIN) else $error("short length below limit");
	a_sel_legal: assert property (@(posedge clk_sys) disable iff (!arst_n)
		regs[FREG_SELECT] == SEL_ACTIVE || regs[FREG_SELECT] == SEL_STANDARD)
		else $error("illegal format selection");

endmodule // dfc_format_bank

// ---- tb/dfc_master_model.sv ----
module dfc_master_model
	import dfc_pkg::*;
(
	input  wire logic      clk_sys,   // system clock
	input  wire logic      respValid, // response strobe
	input  wire dfc_resp_t resp,      // response word
	output dfc_cmd_t       cmd,       // command fields
	output logic           cmdValid,  // command strobe
	output logic           frameEnd   // end of frame
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cmd = '0;
		cmdValid = 1'b0;
		frameEnd = 1'b0;
	end

	// one whole frame: command, listen for the answer, then frame end
	task automatic send(input dfc_cmd_t c, output logic got, output dfc_resp_t r);
		got = 1'b0;
		r = '0;
		@(negedge clk_sys);
		cmd = c;
		cmdValid = 1'b1;
		repeat (2) begin
			@(negedge clk_sys);
			cmdValid = 1'b0;
			cmd = ~c; // stale fields must not look like the last command
			if (respValid === 1'b1) begin
				got = 1'b1;
				r = resp;
			end
		end
		@(negedge clk_sys);
		frameEnd = 1'b1;
		@(negedge clk_sys);
		frameEnd = 1'b0;
		@(negedge clk_sys);
	endtask
endmodule // dfc_master_model

// ---- tb/test_dfc_cmd_decoder.sv ----
module test_dfc_cmd_decoder
	import dfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] DEV = 4'h5;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic cmdValid, frameEnd, respValid, fmtActive, modeBit, otpProgram, got;
	logic nonvolatileEnableFlag = 1'b0;
	logic [3:0] devAddr = DEV;
	dfc_cmd_t cmd;
	dfc_resp_t resp, r;
	logic [63:0] userBytes, ub;
	logic [5:0] otpWhere, where;
	int num_errors = 0, checks_done = 0, cycles = 0, progs = 0;

	always #20 clk_sys = ~clk_sys;

	dfc_cmd_decoder dfc_cmd_decoder_i (.clk_sys(clk_sys), .arst_n(arst_n), .cmdValid(cmdValid),
		.cmd(cmd), .frameEnd(frameEnd), .devAddr(devAddr),
		.nonvolatileEnableFlag(nonvolatileEnableFlag), .resp(resp), .respValid(respValid),
		.fmtActive(fmtActive), .modeBit(modeBit), .userBytes(userBytes),
		.otpProgram(otpProgram), .otpWhere(otpWhere));
	dfc_master_model dfc_master_model_i (.clk_sys(clk_sys), .respValid(respValid), .resp(resp),
		.cmd(cmd), .cmdValid(cmdValid), .frameEnd(frameEnd));

	// sampled mid-cycle, away from the edge that launches the pulse
	always @(negedge clk_sys) begin
		cycles++;
		if (otpProgram === 1'b1) begin
			progs++;
			where = otpWhere;
		end
		if (cycles == 3000) begin
			num_errors++;
			end_of_test();
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [65:0] seen, input logic [65:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic fc(input dfc_frame_t f, input logic [3:0] a, input logic rw,
		input logic [2:0] i, input logic [3:0] v);
		dfc_cmd_t c;
		c = '{frame: f, data: {rw, i, v}, addr: a, code: CMD_FORMAT_CTRL, bank: 2'b00};
		dfc_master_model_i.send(c, got, r);
	endtask

	task automatic rdchk(input logic [2:0] i, input logic [3:0] exp);
		fc(DFC_FRM_STD_LONG, DEV, 1'b0, i, ~exp);
		chk(got, 1'b1, "read unanswered");
		chk(r, {DEV, RESP_FMT_TAG, 1'b0, i, exp}, "read response");
	endtask

	task automatic wr(input logic [2:0] i, input logic [3:0] v);
		fc(DFC_FRM_ENH_LONG, DEV, 1'b1, i, v);
		chk(got, 1'b1, "write unanswered");
		chk({r.addr, r.tag, r.body[7:4]}, {DEV, RESP_FMT_TAG, 1'b1, i}, "write response");
		chk(r.body[3:0], v, "write echo");
	endtask

	task automatic nv(input logic [1:0] b, input logic [3:0] n, input logic [3:0] d,
		input logic fl, input logic used);
		dfc_cmd_t c;
		int p;
		nonvolatileEnableFlag = fl;
		p = progs;
		c = '{frame: DFC_FRM_STD_LONG, data: {n, d}, addr: DEV, code: CMD_WRITE_NVM, bank: b};
		dfc_master_model_i.send(c, got, r);
		chk(got, 1'b1, "nvm unanswered");
		if (fl)
			chk({r.addr, r.tag, r.body[7:4]}, {DEV, n, 2'b11, b}, "programmed answer");
		chk(progs - p, fl & used, "program pulse count");
		if (fl & used)
			chk(where, {b, n}, "program place");
		if (!fl)
			chk(r, {DEV, 4'h0, 4'hf, DEV}, "mirror answer");
		if (!used)
			chk(r.body[3:0], DEV, "unused answer");
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		chk({fmtActive, modeBit, userBytes}, '0, "outputs after reset");
		chk({respValid, otpProgram, otpWhere, resp}, '0, "strobes after reset");
		for (int i = 0; i < 8; i++)
			rdchk(i[2:0], FREG_RESET[4*i+:4]);
	endtask

	task automatic t_limits;
		wr(FREG_CRC_LEN, 4'h9);
		rdchk(FREG_CRC_LEN, 4'h4);
		wr(FREG_CRC_LEN, CRC_LEN_MAX);
		rdchk(FREG_CRC_LEN, 4'h8);
		wr(FREG_SW_LEN, 4'h7);
		rdchk(FREG_SW_LEN, 4'h8);
		wr(FREG_SW_LEN, 4'hf);
		rdchk(FREG_SW_LEN, 4'hf);
		wr(3'h0, 4'h3);
		rdchk(3'h0, 4'h3);
	endtask

	task automatic t_select;
		wr(FREG_SELECT, 4'h3);
		chk(fmtActive, 1'b0, "odd select taken");
		rdchk(FREG_SELECT, 4'h0);
		wr(FREG_SELECT, SEL_ACTIVE);
		chk(fmtActive, 1'b1, "select active");
		wr(FREG_SELECT, SEL_STANDARD);
		chk(fmtActive, 1'b0, "select standard");
	endtask

	task automatic t_refused;
		fc(DFC_FRM_SHORT, DEV, 1'b1, 3'h2, 4'h1);
		chk(got, 1'b0, "short frame answered");
		fc(DFC_FRM_OTHER, DEV, 1'b1, 3'h2, 4'h1);
		chk(got, 1'b0, "other frame answered");
		fc(DFC_FRM_STD_LONG, DEV ^ 4'h1, 1'b1, 3'h2, 4'h1);
		chk(got, 1'b0, "foreign address answered");
		rdchk(3'h2, 4'ha);
		fc(DFC_FRM_STD_LONG, ADDR_BROADCAST, 1'b1, 3'h2, 4'h3);
		chk(got, 1'b0, "broadcast answered");
		rdchk(3'h2, 4'h3);
	endtask

	task automatic t_nvm;
		ub = '0;
		nv(BANK_HIGH, NIB_MODE, 4'hd, 1'b0, 1'b1);
		chk(modeBit, 1'b0, "mode took other bits");
		nv(BANK_HIGH, NIB_MODE, 4'h2, 1'b1, 1'b1);
		chk(modeBit, 1'b1, "mode bit");
		nv(BANK_LOW, NIB_UD6_LO, 4'h9, 1'b1, 1'b1);
		nv(BANK_LOW, NIB_UD7_LO, 4'h6, 1'b0, 1'b1);
		ub[43:40] = 4'h9;
		ub[51:48] = 4'h6;
		for (int k = 0; k < 8; k++) begin
			nv(BANK_HIGH, NIB_UD_HI + k[3:0], 4'hf - k[3:0], 1'b1, 1'b1);
			ub[8*k+4+:4] = 4'hf - k[3:0];
		end
		chk(userBytes, ub, "user bytes");
		// unused places must leave every mirror alone
		nv(2'b11, 4'h6, 4'h0, 1'b1, 1'b0);
		nv(2'b11, 4'hb, 4'h0, 1'b1, 1'b0);
		nv(BANK_LOW, 4'hf, 4'h0, 1'b1, 1'b0);
		nv(BANK_HIGH, 4'h2, 4'h0, 1'b1, 1'b0);
		chk({modeBit, userBytes}, {1'b1, ub}, "unused wrote");
	endtask

	initial begin
		repeat (12) @(negedge clk_sys);
		arst_n = 1'b1;
		t_reset();
		t_limits();
		t_select();
		t_refused();
		t_nvm();
		end_of_test();
	end
endmodule // test_dfc_cmd_decoder
